// file: bench/drive_stop_and_torque_modes_bench.sv
`timescale 1ns/10ps
module drive_stop_and_torque_modes_bench;
    localparam int T = 4;
    localparam int D = 10;
    logic               clk_sys, arst_n, reg_wr, reg_rd, run_req, drive_en, trip;
    logic               ramp_zero, ramp_at_ref, zero_speed, low_speed_det, orient_done;
    logic               inverter_en, ramp_bypass, ramp_down, speed_ctrl_mode, dc_inject, lf_inject;
    logic               orient_req, drive_ready;
    logic [3:0]         reg_addr;
    logic [7:0]         inj_level;
    logic [31:0]        reg_wdata, reg_rdata;
    logic signed [15:0] final_speed_dem, user_speed_dem, torque_ref, speed_loop_out, torque_ff_in;
    logic signed [15:0] speed_ref, speed_limit, torque_dem;
    int                 bad_count, comparisons;
    dsm_stop_ctrl #(.W(16), .TICK_CYC(T)) u_dsm_stop_ctrl (
        .clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .run_req, .drive_en,
        .trip, .ramp_zero, .ramp_at_ref, .zero_speed, .low_speed_det, .orient_done, .final_speed_dem,
        .user_speed_dem, .torque_ref, .speed_loop_out, .torque_ff_in, .inverter_en, .ramp_bypass,
        .ramp_down, .speed_ctrl_mode, .dc_inject, .lf_inject, .orient_req, .drive_ready, .speed_ref,
        .speed_limit, .torque_dem, .inj_level
    );
    dsm_plant_model u_dsm_plant_model (
        .clk_sys, .arst_n, .dly(8'(D)), .inj_level, .ramp_down, .lf_inject, .orient_req,
        .ramp_bypass, .speed_ctrl_mode, .ramp_zero, .ramp_at_ref, .zero_speed, .low_speed_det, .orient_done
    );
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic to_ready;
        for (int n = 0; n < 400 && drive_ready !== 1'b1; n++) @(posedge clk_sys);
        #1;
        chk(32'(drive_ready), 32'h1);
    endtask
    task automatic lim(input logic signed [15:0] f, input logic signed [15:0] t, input logic [31:0] exp);
        @(posedge clk_sys);
        final_speed_dem <= f;
        torque_ref      <= t;
        run_req         <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(32'(speed_limit), exp);
        chk(32'(ramp_bypass), 32'h1);
    endtask
    task automatic coiler;
        wr(dsm_pkg::ADDR_CTRL, 32'h39);
        user_speed_dem <= 16'sh003C;
        lim(16'sh0064, 16'sh000A, 32'sh64);
        lim(16'sh0064, -16'sh000A, -32'sh5);
        lim(-16'sh0064, -16'sh000A, -32'sh64);
        lim(-16'sh0064, 16'sh000A, 32'sh5);
        @(posedge clk_sys);
        run_req <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(32'(speed_ctrl_mode), 32'h1);
        chk(32'(speed_ref), 32'sh3C);
        to_ready();
    endtask
    task automatic feed_fwd(input logic signed [15:0] s, input logic signed [15:0] f, input logic [31:0] exp);
        @(posedge clk_sys);
        speed_loop_out <= s;
        torque_ff_in   <= f;
        run_req        <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(32'(torque_dem), exp);
        chk(32'(speed_ctrl_mode), 32'h1);
    endtask
    task automatic stop_seq(input logic [31:0] ctrl, input int exp, input logic [3:0] fl,
                            input logic [3:0] msk, input logic again);
        logic [3:0] seen;
        int         n;
        seen = 4'h0;
        n = 0;
        wr(dsm_pkg::ADDR_CTRL, ctrl);
        run_req <= 1'b1;
        repeat (4) @(posedge clk_sys);
        run_req <= 1'b0;
        #1;
        chk(32'(drive_ready), 32'h0);
        do begin
            @(posedge clk_sys);
            if (n == 5) run_req <= again;
            #1;
            n++;
            if (n > 1) seen |= {inverter_en, dc_inject, lf_inject, orient_req};
        end while (drive_ready !== 1'b1 && n < 400);
        chk(32'(n >= exp && n <= exp + 12), 32'h1);
        chk(32'(seen & msk), 32'(fl & msk));
        // Disable clears any restart accepted after ready
        @(posedge clk_sys);
        run_req  <= 1'b0;
        drive_en <= 1'b0;
        @(posedge clk_sys);
        drive_en <= 1'b1;
    endtask
    task automatic final_report;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Whole run needs under 1000 cycles
    initial begin
        #(6000 * 100);
        bad_count++;
        final_report();
    end
    initial begin
        {arst_n, reg_wr, reg_rd, run_req, trip} = 5'h00;
        drive_en = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        {final_speed_dem, user_speed_dem, torque_ref, speed_loop_out, torque_ff_in} = 80'h0;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(dsm_pkg::ADDR_CTRL, 32'h1);
        rd(dsm_pkg::ADDR_BRAKE, 32'h32);
        rd(dsm_pkg::ADDR_INJ_LVL, 32'h0);
        wr(4'h2, 32'hFF);
        rd(4'h2, 32'h0);
        wr(dsm_pkg::ADDR_INJ_LVL, 32'h99);
        rd(dsm_pkg::ADDR_INJ_LVL, 32'h99);
        chk(32'(inj_level), 32'h99);
        coiler();
        wr(dsm_pkg::ADDR_CTRL, 32'h49);
        feed_fwd(16'sh0064, 16'sh0017, 32'sh7B);
        feed_fwd(16'sh7D00, 16'sh03E8, 32'sh7FFF);
        @(posedge clk_sys);
        run_req <= 1'b0;
        to_ready();
        stop_seq(32'h0, 80, 4'h0, 4'hF, 1'b1);
        stop_seq(32'h1, D + 40, 4'h8, 4'hF, 1'b0);
        stop_seq(32'h2, D + 40, 4'h4, 4'h7, 1'b0);
        stop_seq(32'h3, D + 40, 4'h6, 4'h7, 1'b1);
        stop_seq(32'h4, 200, 4'h4, 4'h7, 1'b1);
        wr(dsm_pkg::ADDR_BRAKE, 32'hFF);
        rd(dsm_pkg::ADDR_BRAKE, 32'hFA);
        wr(dsm_pkg::ADDR_BRAKE, 32'h0A);
        stop_seq(32'h4, 80, 4'h4, 4'h7, 1'b0);
        wr(dsm_pkg::ADDR_BRAKE, 32'h00);
        stop_seq(32'h4, 80, 4'h4, 4'h7, 1'b0);
        stop_seq(32'h8, 0, 4'h0, 4'h8, 1'b0);
        stop_seq(32'h9, D, 4'h0, 4'h0, 1'b0);
        stop_seq(32'hA, D, 4'h0, 4'h0, 1'b0);
        stop_seq(32'hB, 2 * D, 4'h1, 4'h1, 1'b0);
        final_report();
    end
endmodule // drive_stop_and_torque_modes_bench

// file: bench/dsm_plant_model.sv
`timescale 1ns/10ps
module dsm_plant_model (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic [7:0] dly,
    input  wire logic [7:0] inj_level,
    input  wire logic       ramp_down,
    input  wire logic       lf_inject,
    input  wire logic       orient_req,
    input  wire logic       ramp_bypass,
    input  wire logic       speed_ctrl_mode,
    output logic            ramp_zero,
    output logic            ramp_at_ref,
    output logic            zero_speed,
    output logic            low_speed_det,
    output logic            orient_done
);
    logic [4:0] act_ff;
    logic [7:0] cnt_ff;
    logic [4:0] act;
    logic       done;
    assign act = {ramp_down, lf_inject, orient_req, ramp_bypass, speed_ctrl_mode};
    assign done = (act_ff == act) && cnt_ff >= dly;
    // Settling restarts whenever the requested action changes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            act_ff <= 5'h00;
            cnt_ff <= 8'h00;
        end else begin
            act_ff <= act;
            cnt_ff <= (act_ff != act) ? 8'h00 : (done ? cnt_ff : cnt_ff + 8'h01);
        end
    end
    assign ramp_zero     = ramp_down && done;
    assign ramp_at_ref   = speed_ctrl_mode && done;
    assign zero_speed    = ramp_bypass && done;
    assign low_speed_det = lf_inject && done && inj_level >= 8'h80;
    assign orient_done   = orient_req && done;
endmodule // dsm_plant_model

// file: inc/dsm_pkg.sv
package dsm_pkg;

    // Register map, byte addresses
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_INJ_LVL = 4'h4;
    localparam logic [3:0] ADDR_BRAKE   = 4'h8;
    localparam logic [3:0] ADDR_STATUS  = 4'hC;

    // Control register fields
    localparam int CTRL_SEL_LSB   = 0;
    localparam int CTRL_CL_BIT    = 3;
    localparam int CTRL_TMODE_LSB = 4;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_READY_BIT = 3;
    localparam int STAT_SUB_BIT   = 4;
    localparam int STAT_SEL_LSB   = 8;

    // Reset values and braking time limit
    localparam logic [2:0] SEL_RST   = 3'h1;
    localparam logic [2:0] TMODE_RST = 3'h0;
    localparam logic [7:0] INJ_RST   = 8'h00;
    localparam logic [7:0] BRAKE_RST = 8'h32;
    localparam logic [7:0] BRAKE_MAX = 8'hFA;

    // Stop mode selector codes, open loop
    localparam logic [2:0] OL_COAST  = 3'h0;
    localparam logic [2:0] OL_RAMP   = 3'h1;
    localparam logic [2:0] OL_RAMPDC = 3'h2;
    localparam logic [2:0] OL_SENSED = 3'h3;
    localparam logic [2:0] OL_TIMED  = 3'h4;
    // Stop mode selector codes, closed loop
    localparam logic [2:0] CL_COAST  = 3'h0;
    localparam logic [2:0] CL_RAMP   = 3'h1;
    localparam logic [2:0] CL_NORAMP = 3'h2;
    localparam logic [2:0] CL_ORIENT = 3'h3;

    // Torque mode codes handled here
    localparam logic [2:0] TM_COILER = 3'h3;
    localparam logic [2:0] TM_SPD_FF = 3'h4;

    // Coiler/uncoiler opposite-torque speed limit
    localparam int COIL_LIM_RPM = 5;

    // Timing: clock, tick and stop delays
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned TICK_MS       = 100;
    localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned ONE_S_MS      = 1000;
    localparam int unsigned COAST_HOLD_MS = 2000;
    localparam logic [7:0]  ONE_S_TICKS   = 8'(ONE_S_MS / TICK_MS);
    localparam logic [7:0]  COAST_TICKS   = 8'(COAST_HOLD_MS / TICK_MS);

    typedef enum logic [2:0] {
        ST_READY = 3'b000,
        ST_RUN   = 3'b001,
        ST_PH1   = 3'b011,
        ST_PH2   = 3'b010,
        ST_CLSTP = 3'b101
    } dsm_state_t;

endpackage

// file: rtl/dsm_stop_ctrl.sv
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
// Operation
// [R1] Coiler, positive demand: negative torque limits -5rpm
// [R2] Coiler, negative demand: positive torque limits +5rpm
// [R3] Coiler run state bypasses ramps
// [R4] Coiler leaving run uses selected stop mode
// [R5] Coiler ramp stop: speed control, user ref, down
// [R6] Configure coiler with coast or no-ramp only
// [R7] Torque mode 4 adds feed-forward to speed output
// [R8] Open loop stop codes: coast, ramp, dc, sensed, timed
// [R9] Closed loop codes: coast, ramp, no-ramp, orient
// [R10] Open loop stop: decelerate phase, then stopped phase
// [R11] Coast: inverter off, re-enable refused 2s
// [R12] Ramp plus dc: ramp, then 1s injection
// [R13] Sensed braking: inject until low speed detected
// [R14] Sensed braking needs about half rated current
// [R15] Timed braking: brake time minus 1s, then 1s
// [R16] Timed braking: each phase at least 1s
// [R17] Braking stops must reach ready before restart
// [R18] Ramp stop: ramp to zero, hold 1s enabled
// [R19] Closed loop: single action, then ready
// [R20] Braking time accepted from 0 to 25s
module dsm_stop_ctrl #(
    parameter int          W        = 16,
    parameter int unsigned TICK_CYC = dsm_pkg::TICK_CYC
) (
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    input  wire logic [3:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    input  wire logic                run_req,
    input  wire logic                drive_en,
    input  wire logic                trip,
    input  wire logic                ramp_zero,
    input  wire logic                ramp_at_ref,
    input  wire logic                zero_speed,
    input  wire logic                low_speed_det,
    input  wire logic                orient_done,
    input  wire logic signed [W-1:0] final_speed_dem,
    input  wire logic signed [W-1:0] user_speed_dem,
    input  wire logic signed [W-1:0] torque_ref,
    input  wire logic signed [W-1:0] speed_loop_out,
    input  wire logic signed [W-1:0] torque_ff_in,
    output logic                     inverter_en,
    output logic                     ramp_bypass,
    output logic                     ramp_down,
    output logic                     speed_ctrl_mode,
    output logic                     dc_inject,
    output logic                     lf_inject,
    output logic                     orient_req,
    output logic                     drive_ready,
    output logic signed [W-1:0]      speed_ref,
    output logic signed [W-1:0]      speed_limit,
    output logic signed [W-1:0]      torque_dem,
    output logic      [7:0]          inj_level
);
    localparam logic signed [W-1:0] LIM_POS = W'(dsm_pkg::COIL_LIM_RPM);
    localparam logic signed [W-1:0] LIM_NEG = -LIM_POS;
    localparam logic signed [W-1:0] S_MAX   = {1'b0, {(W-1){1'b1}}};
    localparam logic signed [W-1:0] S_MIN   = {1'b1, {(W-1){1'b0}}};

    dsm_pkg::dsm_state_t state_ff, nxt_state;
    logic       sub_ff, nxt_sub;
    logic [2:0] sel_ff, sel_lat_ff, sel_eff, tmode_ff;
    logic       cl_ff;
    logic [7:0] brake_ff;
    logic       fault, coiler, trq_mode, tmr_load, tmr_done;
    logic [7:0] tmr_val, ph1_time;

    function automatic logic signed [W-1:0] sat_add(input logic signed [W-1:0] a, input logic signed [W-1:0] b);
        logic signed [W:0] s;
        s = {a[W-1], a} + {b[W-1], b};
        if (s[W] != s[W-1]) begin
            sat_add = s[W] ? S_MIN : S_MAX;
        end else begin
            sat_add = s[W-1:0];
        end
    endfunction

    assign fault    = trip || !drive_en;
    assign coiler   = cl_ff && (tmode_ff == dsm_pkg::TM_COILER);
    assign trq_mode = cl_ff && (tmode_ff != 3'h0) && (tmode_ff != dsm_pkg::TM_SPD_FF);
    assign sel_eff  = (state_ff == dsm_pkg::ST_RUN) ? sel_ff : sel_lat_ff;

    // Register writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_ff    <= dsm_pkg::SEL_RST;
            cl_ff     <= 1'b0;
            tmode_ff  <= dsm_pkg::TMODE_RST;
            inj_level <= dsm_pkg::INJ_RST;
            brake_ff  <= dsm_pkg::BRAKE_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                dsm_pkg::ADDR_CTRL: begin
                    sel_ff   <= reg_wdata[dsm_pkg::CTRL_SEL_LSB +: 3];
                    cl_ff    <= reg_wdata[dsm_pkg::CTRL_CL_BIT];
                    tmode_ff <= reg_wdata[dsm_pkg::CTRL_TMODE_LSB +: 3];
                end
                dsm_pkg::ADDR_INJ_LVL: inj_level <= reg_wdata[7:0];
                dsm_pkg::ADDR_BRAKE: begin
                    // Clamp to 25.0 s in tenths
                    if (reg_wdata[31:8] != 24'h0 || reg_wdata[7:0] > dsm_pkg::BRAKE_MAX) begin // see [R20]
                        brake_ff <= dsm_pkg::BRAKE_MAX;
                    end else begin
                        brake_ff <= reg_wdata[7:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Register reads, data in the following cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                dsm_pkg::ADDR_CTRL:    reg_rdata <= {25'h0, tmode_ff, cl_ff, sel_ff};
                dsm_pkg::ADDR_INJ_LVL: reg_rdata <= {24'h0, inj_level};
                dsm_pkg::ADDR_BRAKE:   reg_rdata <= {24'h0, brake_ff};
                dsm_pkg::ADDR_STATUS:  reg_rdata <= {21'h0, sel_lat_ff, 3'h0, sub_ff, drive_ready, state_ff};
                default:               reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // Stop sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_sub   = sub_ff;
        if (fault) begin
            nxt_state = dsm_pkg::ST_READY; // see [R17]
            nxt_sub   = 1'b0;
        end else begin
            case (state_ff)
                dsm_pkg::ST_READY: begin
                    if (run_req) begin
                        nxt_state = dsm_pkg::ST_RUN;
                    end
                end
                dsm_pkg::ST_RUN: begin
                    if (!run_req) begin
                        if (cl_ff) begin
                            nxt_state = dsm_pkg::ST_CLSTP; // see [R4]
                            nxt_sub   = (sel_ff == dsm_pkg::CL_RAMP) && !coiler; // see [R5]
                        end else begin
                            nxt_state = dsm_pkg::ST_PH1; // see [R10]
                        end
                    end
                end
                dsm_pkg::ST_PH1: begin
                    case (sel_lat_ff) // see [R8]
                        dsm_pkg::OL_COAST: nxt_state = dsm_pkg::ST_PH2; // see [R11]
                        dsm_pkg::OL_RAMP, dsm_pkg::OL_RAMPDC: begin
                            if (run_req) begin
                                nxt_state = dsm_pkg::ST_RUN;
                            end else if (ramp_zero) begin
                                nxt_state = dsm_pkg::ST_PH2; // see [R12] [R18]
                            end
                        end
                        dsm_pkg::OL_SENSED: begin
                            if (low_speed_det) begin
                                nxt_state = dsm_pkg::ST_PH2; // see [R13]
                            end
                        end
                        dsm_pkg::OL_TIMED: begin
                            if (tmr_done) begin
                                nxt_state = dsm_pkg::ST_PH2; // see [R15]
                            end
                        end
                        default: nxt_state = dsm_pkg::ST_READY;
                    endcase
                end
                dsm_pkg::ST_PH2: begin
                    if (tmr_done) begin
                        nxt_state = dsm_pkg::ST_READY; // see [R10]
                    end
                end
                dsm_pkg::ST_CLSTP: begin
                    case (sel_lat_ff) // see [R9]
                        dsm_pkg::CL_COAST: nxt_state = dsm_pkg::ST_READY; // see [R19]
                        dsm_pkg::CL_RAMP: begin
                            if (!sub_ff) begin
                                nxt_sub = ramp_at_ref; // see [R5]
                            end else if (ramp_zero) begin
                                nxt_state = dsm_pkg::ST_READY;
                            end
                        end
                        dsm_pkg::CL_NORAMP: begin
                            if (zero_speed) begin
                                nxt_state = dsm_pkg::ST_READY;
                            end
                        end
                        dsm_pkg::CL_ORIENT: begin
                            if (!sub_ff) begin
                                nxt_sub = ramp_zero;
                            end else if (orient_done) begin
                                nxt_state = dsm_pkg::ST_READY;
                            end
                        end
                        default: nxt_state = dsm_pkg::ST_READY;
                    endcase
                end
                default: nxt_state = dsm_pkg::ST_READY;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= dsm_pkg::ST_READY;
            sub_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sub_ff   <= nxt_sub;
        end
    end

    // Mode is frozen for the whole stop
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_lat_ff <= dsm_pkg::SEL_RST;
        end else if (state_ff == dsm_pkg::ST_RUN && nxt_state != dsm_pkg::ST_RUN) begin
            sel_lat_ff <= sel_ff;
        end
    end

    // Phase timers
    assign ph1_time = (brake_ff > 8'(2 * dsm_pkg::ONE_S_TICKS)) ? brake_ff - dsm_pkg::ONE_S_TICKS
                                                                 : dsm_pkg::ONE_S_TICKS; // see [R16]
    assign tmr_load = (nxt_state != state_ff) && (nxt_state == dsm_pkg::ST_PH1 || nxt_state == dsm_pkg::ST_PH2);
    always_comb begin
        if (nxt_state == dsm_pkg::ST_PH1) begin
            tmr_val = ph1_time; // see [R15]
        end else if (sel_eff == dsm_pkg::OL_COAST) begin
            tmr_val = dsm_pkg::COAST_TICKS; // see [R11]
        end else begin
            tmr_val = dsm_pkg::ONE_S_TICKS; // see [R12] [R18]
        end
    end

    dsm_tick_timer #(
        .TICK_CYC (TICK_CYC)
    ) u_timer (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    // Registered drive outputs
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            inverter_en     <= 1'b0;
            ramp_bypass     <= 1'b0;
            ramp_down       <= 1'b0;
            speed_ctrl_mode <= 1'b1;
            dc_inject       <= 1'b0;
            lf_inject       <= 1'b0;
            orient_req      <= 1'b0;
            drive_ready     <= 1'b1;
        end else begin
            inverter_en <= (state_ff == dsm_pkg::ST_RUN)
                        || (state_ff != dsm_pkg::ST_READY && sel_lat_ff != dsm_pkg::OL_COAST); // see [R11] [R18]
            ramp_bypass <= (state_ff == dsm_pkg::ST_RUN && coiler) // see [R3]
                        || (state_ff == dsm_pkg::ST_CLSTP && sel_lat_ff == dsm_pkg::CL_NORAMP);
            ramp_down   <= (state_ff == dsm_pkg::ST_PH1 && (sel_lat_ff == dsm_pkg::OL_RAMP
                                                         || sel_lat_ff == dsm_pkg::OL_RAMPDC))
                        || (state_ff == dsm_pkg::ST_CLSTP && sel_lat_ff == dsm_pkg::CL_RAMP && sub_ff)
                        || (state_ff == dsm_pkg::ST_CLSTP && sel_lat_ff == dsm_pkg::CL_ORIENT && !sub_ff);
            speed_ctrl_mode <= !(state_ff == dsm_pkg::ST_RUN && trq_mode); // see [R5]
            dc_inject   <= (state_ff == dsm_pkg::ST_PH1 && sel_lat_ff == dsm_pkg::OL_TIMED)
                        || (state_ff == dsm_pkg::ST_PH2 && sel_lat_ff >= dsm_pkg::OL_RAMPDC
                                                        && sel_lat_ff <= dsm_pkg::OL_TIMED); // see [R12]
            lf_inject   <= state_ff == dsm_pkg::ST_PH1 && sel_lat_ff == dsm_pkg::OL_SENSED; // see [R13]
            orient_req  <= state_ff == dsm_pkg::ST_CLSTP && sel_lat_ff == dsm_pkg::CL_ORIENT && sub_ff;
            drive_ready <= state_ff == dsm_pkg::ST_READY;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            speed_ref   <= '0;
            speed_limit <= '0;
            torque_dem  <= '0;
        end else begin
            if (state_ff == dsm_pkg::ST_RUN) begin
                speed_ref <= final_speed_dem;
            end else if (state_ff == dsm_pkg::ST_CLSTP && sel_lat_ff == dsm_pkg::CL_RAMP && !sub_ff) begin
                speed_ref <= user_speed_dem; // see [R5]
            end else begin
                speed_ref <= '0;
            end
            if (!coiler) begin
                speed_limit <= final_speed_dem;
            end else if (!final_speed_dem[W-1]) begin
                speed_limit <= torque_ref[W-1] ? LIM_NEG : final_speed_dem; // see [R1]
            end else begin
                speed_limit <= torque_ref[W-1] ? final_speed_dem : LIM_POS; // see [R2]
            end
            if (cl_ff && tmode_ff == dsm_pkg::TM_SPD_FF) begin
                torque_dem <= sat_add(speed_loop_out, torque_ff_in); // see [R7]
            end else if (state_ff == dsm_pkg::ST_RUN && trq_mode) begin
                torque_dem <= torque_ref;
            end else begin
                torque_dem <= speed_loop_out;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_coil_ramp_stop;
        state_ff == dsm_pkg::ST_RUN && !run_req && !fault && coiler && sel_ff == dsm_pkg::CL_RAMP;
    endsequence
    sequence s_user_ref_phase;
        state_ff == dsm_pkg::ST_CLSTP && !sub_ff;
    endsequence

    coil_pos_lim_a: assert property (coiler && !final_speed_dem[W-1] && torque_ref[W-1] // see [R1]
        |=> speed_limit == LIM_NEG) else $error("coiler negative limit wrong");
    coil_neg_lim_a: assert property (coiler && final_speed_dem[W-1] && !torque_ref[W-1] // see [R2]
        |=> speed_limit == LIM_POS) else $error("coiler positive limit wrong");
    coil_bypass_a: assert property (state_ff == dsm_pkg::ST_RUN && coiler |=> ramp_bypass) // see [R3]
        else $error("ramps active in coiler run");
    coil_ramp_stop_a: assert property (s_coil_ramp_stop ##1 s_user_ref_phase // see [R5]
        |=> speed_ctrl_mode && speed_ref == $past(user_speed_dem)) else $error("coiler ramp stop ref wrong");
    ff_sum_a: assert property (cl_ff && tmode_ff == dsm_pkg::TM_SPD_FF && speed_loop_out[W-1:8] == '0 // see [R7]
        && torque_ff_in[W-1:8] == '0 |=> torque_dem == $past(speed_loop_out) + $past(torque_ff_in))
        else $error("feed-forward not added");
    ol_phase_a: assert property (state_ff == dsm_pkg::ST_RUN && !run_req && !fault && !cl_ff // see [R10]
        |=> state_ff == dsm_pkg::ST_PH1) else $error("open loop stop not in phase one");
    coast_off_a: assert property (state_ff == dsm_pkg::ST_PH2 && sel_lat_ff == dsm_pkg::OL_COAST // see [R11]
        |=> !inverter_en && state_ff != dsm_pkg::ST_RUN) else $error("coast re-enabled early");
    brake_lock_a: assert property ((state_ff == dsm_pkg::ST_PH1 || state_ff == dsm_pkg::ST_PH2) // see [R17]
        && sel_lat_ff >= dsm_pkg::OL_SENSED |=> state_ff != dsm_pkg::ST_RUN) else $error("restart during braking");
    dc_phase2_a: assert property (state_ff == dsm_pkg::ST_PH2 && sel_lat_ff == dsm_pkg::OL_RAMPDC // see [R12]
        |=> dc_inject && inverter_en) else $error("no dc injection in phase two");
    timed_min_a: assert property (tmr_load && nxt_state == dsm_pkg::ST_PH1 // see [R16]
        |-> tmr_val >= dsm_pkg::ONE_S_TICKS) else $error("timed phase one below one second");
    cl_single_a: assert property (state_ff == dsm_pkg::ST_CLSTP && sel_lat_ff == dsm_pkg::CL_COAST // see [R19]
        |=> state_ff == dsm_pkg::ST_READY ##1 drive_ready) else $error("closed loop coast not ready");
endmodule // dsm_stop_ctrl

// file: rtl/dsm_tick_timer.sv
`timescale 1ns/10ps
module dsm_tick_timer #(
    parameter int unsigned TICK_CYC = dsm_pkg::TICK_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    output logic            done
);
    logic [31:0] div_ff;
    logic [7:0]  cnt_ff;
    logic        run_ff;
    logic        tick;

    assign tick = (div_ff == 32'(TICK_CYC - 1));

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_ff <= 32'h0;
        end else if (load || tick) begin
            div_ff <= 32'h0;
        end else begin
            div_ff <= div_ff + 32'h1;
        end
    end

    // Counts whole ticks; a zero load finishes on the next cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 8'h0;
            run_ff <= 1'b0;
            done   <= 1'b0;
        end else if (load) begin
            cnt_ff <= load_val;
            run_ff <= 1'b1;
            done   <= 1'b0;
        end else if (run_ff && (cnt_ff == 8'h0 || (tick && cnt_ff == 8'h1))) begin
            cnt_ff <= 8'h0;
            run_ff <= 1'b0;
            done   <= 1'b1;
        end else begin
            if (run_ff && tick) begin
                cnt_ff <= cnt_ff - 8'h1;
            end
            done <= 1'b0;
        end
    end
endmodule // dsm_tick_timer
